// >>> core/rxf_mac.sv
// Receive address filter, gap strip, pause gate and widened client port
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module rxf_mac (
  input  wire logic            aclk,     // Receive MAC clock
  input  wire logic            aresetn,  // Sync reset, active low
  input  wire rxf_pkg::rxf_in_t rx_i,    // Narrow words from the MAC core
  output var  rxf_pkg::rxf_out_t st_o,   // Widened client stream
  output var  rxf_pkg::rxf_pause_t pause_o, // Pause request to transmit side
  input  wire logic            awvalid,  // AXI write address valid
  output logic                 awready,  // AXI write address ready
  input  wire logic [15:0]     awaddr,   // AXI write address
  input  wire logic            wvalid,   // AXI write data valid
  output logic                 wready,   // AXI write data ready
  input  wire logic [31:0]     wdata,    // AXI write data
  input  wire logic [3:0]      wstrb,    // AXI byte strobes
  output logic                 bvalid,   // AXI write response valid
  input  wire logic            bready,   // AXI write response ready
  output logic [1:0]           bresp,    // AXI write response
  input  wire logic            arvalid,  // AXI read address valid
  output logic                 arready,  // AXI read address ready
  input  wire logic [15:0]     araddr,   // AXI read address
  output logic                 rvalid,   // AXI read data valid
  input  wire logic            rready,   // AXI read data ready
  output logic [31:0]          rdata,    // AXI read data
  output logic [1:0]           rresp     // AXI read response
);
  import rxf_pkg::*;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [31:0] filt_q, maddr_q, dalo_q, dahi_q, pause_q;
  logic [4:0]  stat_q;
  logic        bvalid_q, rvalid_q, wr_go, wr_hit, rd_hit;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q, rd_mux;
  logic [11:0] widx, ridx;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Address and data are taken together; response must drain first
  assign wr_go   = awvalid && wvalid && !bvalid_q;
  assign awready = wr_go;
  assign wready  = wr_go;
  assign widx    = awaddr[13:2];
  assign ridx    = araddr[13:2];
  assign wr_hit  = awaddr[15:14] == 2'h0 && (widx == IDX_FILT || widx == IDX_MADDR
                   || widx == IDX_DA_LO || widx == IDX_DA_HI || widx == IDX_PAUSE || widx == IDX_STAT);
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = !rvalid_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  // Writable registers; the status word ignores writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt_q  <= FILT_RST;
      maddr_q <= MADDR_RST;
      dalo_q  <= DA_RST;
      dahi_q  <= DA_RST;
      pause_q <= PAUSE_RST;
    end else if (wr_go && awaddr[15:14] == 2'h0) begin
      if (widx == IDX_FILT)  filt_q  <= merge(filt_q, wdata, wstrb);
      if (widx == IDX_MADDR) maddr_q <= merge(maddr_q, wdata, wstrb);
      if (widx == IDX_DA_LO) dalo_q  <= merge(dalo_q, wdata, wstrb);
      if (widx == IDX_DA_HI) dahi_q  <= merge(dahi_q, wdata, wstrb);
      if (widx == IDX_PAUSE) pause_q <= merge(pause_q, wdata, wstrb);
    end
  end

  // Write response; unmapped words answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OK;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? RESP_OK : RESP_ERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read decode
  always_comb begin
    rd_hit = araddr[15:14] == 2'h0;
    rd_mux = 32'h0000_0000;
    case (ridx)
      IDX_FILT:  rd_mux = filt_q;
      IDX_MADDR: rd_mux = maddr_q;
      IDX_DA_LO: rd_mux = dalo_q;
      IDX_DA_HI: rd_mux = 32'(dahi_q[15:0]);
      IDX_PAUSE: rd_mux = 32'(pause_q[1:0]);
      IDX_STAT:  rd_mux = 32'(stat_q);
      default:   rd_hit = 1'b0;
    endcase
  end

  // Read data is held until the master takes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OK;
    end else if (arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_hit ? rd_mux : 32'h0000_0000;
      rresp_q  <= rd_hit ? RESP_OK : RESP_ERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Address classification and filter
  // ----------------------------------------
  logic [47:0] da, da_reg;
  logic [15:0] etype, opcode;
  logic        uni, mc, bc, prom, addr_ok, keep_now, keep_q;
  logic        beat, take, pause_hit;

  assign da_reg = {dahi_q[15:0], dalo_q};
  assign da     = rx_i.data[IN_B*8-1 -: 48];
  assign etype  = rx_i.data[IN_B*8-97 -: 16];
  assign opcode = rx_i.data[IN_B*8-113 -: 16];
  assign uni    = !da[40];
  assign mc     = da[40];
  assign bc     = &da;
  assign prom   = filt_q[FILT_PROM];

  // Check bit off: always match; enable off: never match
  always_comb begin
    if (!maddr_q[MADDR_CHK]) begin
      addr_ok = 1'b1;
    end else if (!maddr_q[MADDR_EN]) begin
      addr_ok = 1'b0;
    end else begin
      addr_ok = da == da_reg;
    end
  end

  // Promiscuous mode skips the address check entirely
  assign keep_now = prom || addr_ok;
  // Idle-only beats are gap octets and are never taken
  assign beat = rx_i.valid && rx_i.payload;
  assign take = beat && (rx_i.sop ? keep_now : keep_q);
  // Enables picked by address class; broadcast counts as multicast
  assign pause_hit = beat && rx_i.sop && keep_now && etype == ETYPE_PAUSE && opcode == OPC_PAUSE
                     && (mc ? pause_q[PAUSE_MC] : pause_q[PAUSE_UNI]);

  // Whole frame follows the decision made on its first beat
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      keep_q <= 1'b0;
    end else if (beat && rx_i.sop) begin
      keep_q <= keep_now;
    end
  end

  // Last frame class, drop and pause seen, for software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= 5'h00;
    end else if (beat && rx_i.sop) begin
      stat_q <= {pause_hit, !keep_now, bc, mc, uni};
    end
  end

  // Pause request pulse toward the transmitter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pause_o <= '0;
    end else begin
      pause_o.valid  <= pause_hit;
      pause_o.quanta <= rx_i.data[IN_B*8-129 -: 16];
    end
  end

  // ----------------------------------------
  // Frame length and error record
  // ----------------------------------------
  logic [CW-1:0] nb, elen, rcnt, cnt_q, eop_at_q;
  logic [LW-1:0] len_q, tot;
  logic          runt, dec, eop_pend_q, crc_q, runt_q, dec_q;

  assign nb   = rx_i.eop ? CW'(IN_B - int'(rx_i.empty)) : CW'(IN_B);
  assign tot  = (rx_i.sop ? '0 : len_q) + LW'(nb);
  assign runt = tot < RUNT_LEN && tot > DEC_LEN;
  assign dec  = tot <= DEC_LEN;

  // Byte count of the frame being taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      len_q <= '0;
    end else if (take) begin
      len_q <= tot;
    end
  end

  // Errors are caught at input end and held for the output end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crc_q  <= 1'b0;
      runt_q <= 1'b0;
      dec_q  <= 1'b0;
    end else if (take && rx_i.eop) begin
      crc_q  <= rx_i.crc_bad;
      runt_q <= runt;
      dec_q  <= dec;
    end
  end

  // ----------------------------------------
  // Width adapter
  // ----------------------------------------
  // Five words in, eight out; the four-word build packs two input words the same way
  logic [BUF_B*8-1:0] buf_q, rem, ins;
  logic [IN_B*8-1:0]  mask;
  logic               emit, eop_out, at_start_q;

  // Output drains 64 bytes a cycle, more than the 40 that arrive,
  // so no back-pressure is needed; one end mark is tracked at a time
  assign eop_out = eop_pend_q && eop_at_q <= CW'(OUT_B);
  assign emit    = eop_out || cnt_q >= CW'(OUT_B);
  assign elen    = eop_out ? eop_at_q : CW'(OUT_B);
  assign rem     = emit ? buf_q << {elen, 3'b000} : buf_q;
  assign rcnt    = emit ? cnt_q - elen : cnt_q;
  // Clear the unused tail so later bytes can be OR-ed in behind it
  assign mask    = ~({(IN_B*8){1'b1}} >> {nb, 3'b000});
  assign ins     = {rx_i.data & mask, {(OUT_B*8){1'b0}}} >> {rcnt, 3'b000};

  // Byte buffer, packed from the top lane down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_q <= '0;
      cnt_q <= '0;
    end else begin
      buf_q <= take ? (rem | ins) : rem;
      cnt_q <= take ? rcnt + nb : rcnt;
    end
  end

  // Position of the pending end of packet inside the buffer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eop_pend_q <= 1'b0;
      eop_at_q   <= '0;
    end else if (take && rx_i.eop) begin
      eop_pend_q <= 1'b1;
      eop_at_q   <= rcnt + nb;
    end else if (eop_out) begin
      eop_pend_q <= 1'b0;
    end else if (emit && eop_pend_q) begin
      eop_at_q   <= eop_at_q - elen;
    end
  end

  // Next word out opens a packet after an end or after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      at_start_q <= 1'b1;
    end else if (emit) begin
      at_start_q <= eop_out;
    end
  end

  // Client stream, all from flops on the receive clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_o <= '0;
    end else begin
      st_o.valid     <= emit;
      st_o.data      <= buf_q[BUF_B*8-1 -: OUT_B*8];
      st_o.sop       <= emit && at_start_q;
      st_o.eop       <= eop_out;
      st_o.empty     <= eop_out ? EW'(OUT_B - int'(eop_at_q)) : '0;
      st_o.fcs_valid <= eop_out;
      st_o.fcs_error <= eop_out && (crc_q || runt_q);
      st_o.error     <= eop_out ? {crc_q, runt_q || dec_q} : 2'h0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic in_pkt_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_pkt_q <= 1'b0;
    end else if (st_o.valid) begin
      in_pkt_q <= !st_o.eop;
    end
  end

  // Stream framing and qualifier checks
  valid_in_pkt_a: assert property (st_o.valid && !st_o.sop |-> in_pkt_q)
    else $error("valid outside packet");
  sop_order_a: assert property (st_o.sop |-> st_o.valid && !in_pkt_q)
    else $error("sop inside packet");
  empty_mid_a: assert property (st_o.valid && !st_o.eop |-> st_o.empty == '0)
    else $error("empty mid packet");
  fcs_qual_a: assert property (st_o.fcs_error |-> st_o.fcs_valid && st_o.eop)
    else $error("fcs error unqualified");
  crc_flag_a: assert property (st_o.error[1] |-> st_o.fcs_error && st_o.fcs_valid)
    else $error("crc flags apart");

  // Address class and keep decisions, seen one cycle after the first beat; gap beats add no bytes
  uni_class_a: assert property (beat && rx_i.sop && !da[40] |=> stat_q[0] && !stat_q[1])
    else $error("unicast class");
  mc_class_a: assert property (beat && rx_i.sop && da[40] |=> stat_q[1] && !stat_q[0])
    else $error("multicast class");
  bcast_class_a: assert property (beat && rx_i.sop && &da |=> stat_q[2] && stat_q[1])
    else $error("broadcast class");
  match_drop_a: assert property (beat && rx_i.sop && !prom && maddr_q[MADDR_CHK] && maddr_q[MADDR_EN]
    && da != da_reg |=> !keep_q) else $error("mismatch kept");
  prom_keep_a: assert property (beat && rx_i.sop && prom |=> keep_q)
    else $error("promiscuous drop");
  chk_off_a: assert property (beat && rx_i.sop && !maddr_q[MADDR_CHK] |=> keep_q)
    else $error("check off drop");
  gap_strip_a: assert property (rx_i.valid && !rx_i.payload && !emit |=> cnt_q == $past(cnt_q))
    else $error("gap bytes kept");

  // Pause requests pass only through the enable of the frame's address class
  pause_gate_a: assert property (pause_o.valid |-> $past(pause_q[PAUSE_MC]) || $past(pause_q[PAUSE_UNI]))
    else $error("pause while disabled");
  pause_sel_a: assert property (pause_o.valid
    |-> ($past(mc) && $past(pause_q[PAUSE_MC])) || (!$past(mc) && $past(pause_q[PAUSE_UNI])))
    else $error("pause enable crossed");

  // Length and CRC verdicts; the end word leaves two or three cycles after the last beat
  runt_fcs_a: assert property (take && rx_i.eop && runt |-> ##2 st_o.eop && st_o.fcs_error)
    else $error("runt without fcs error");
  full_len_a: assert property (take && rx_i.eop && tot >= RUNT_LEN && !rx_i.crc_bad
    |-> ##[2:3] st_o.eop && !st_o.fcs_error && st_o.error == 2'h0) else $error("long frame flagged");
  dec_err_a: assert property (take && rx_i.eop && tot <= DEC_LEN && !rx_i.crc_bad
    |-> ##2 st_o.eop && !st_o.fcs_error && st_o.error[0]) else $error("decode error as runt");
  crc_err_a: assert property (take && rx_i.eop && rx_i.crc_bad |-> ##[2:3] st_o.eop && st_o.error[1])
    else $error("crc error lost");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("bresp dropped");

  sop_eop_c: cover property (st_o.sop ##[1:4] st_o.eop);
  drop_c: cover property (beat && rx_i.sop && !keep_now);
  pause_c: cover property (pause_o.valid);
  one_word_c: cover property (st_o.sop && st_o.eop);
  runt_c: cover property (st_o.eop && st_o.fcs_error && st_o.error == 2'h1);
endmodule : rxf_mac
`default_nettype wire

// >>> core/rxf_pkg.sv
// Constants and carrier types for the receive filter and client port
`default_nettype none
package rxf_pkg;
  // ----------------------------------------
  // Variant and widths
  // ----------------------------------------
  localparam bit IS_100G   = 1'b1;
  localparam int IN_WORDS  = IS_100G ? 5 : 2;
  localparam int OUT_WORDS = IS_100G ? 8 : 4;
  localparam int IN_B      = IN_WORDS * 8;
  localparam int OUT_B     = OUT_WORDS * 8;
  localparam int BUF_B     = IN_B + OUT_B;
  localparam int IEW       = $clog2(IN_B);
  localparam int EW        = $clog2(OUT_B);
  localparam int CW        = $clog2(BUF_B + 1);
  localparam int LW        = 14;
  // ----------------------------------------
  // Register indexes (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [11:0] IDX_FILT  = 12'h103;
  localparam logic [11:0] IDX_MADDR = 12'h140;
  localparam logic [11:0] IDX_DA_LO = 12'h141;
  localparam logic [11:0] IDX_DA_HI = 12'h142;
  localparam logic [11:0] IDX_PAUSE = 12'h143;
  localparam logic [11:0] IDX_STAT  = 12'h144;
  // Field positions
  localparam int FILT_PROM  = 0;
  localparam int MADDR_EN   = 0;
  localparam int MADDR_CHK  = 30;
  localparam int PAUSE_UNI  = 0;
  localparam int PAUSE_MC   = 1;
  // Reset values
  localparam logic [31:0] FILT_RST  = 32'h0000_0000;
  localparam logic [31:0] MADDR_RST = 32'h0000_0000;
  localparam logic [31:0] DA_RST    = 32'h0000_0000;
  localparam logic [31:0] PAUSE_RST = 32'h0000_0000;
  // Frame constants
  localparam logic [LW-1:0] RUNT_LEN = 14'h0040;
  localparam logic [LW-1:0] DEC_LEN  = 14'h0008;
  localparam logic [15:0] ETYPE_PAUSE = 16'h8808;
  localparam logic [15:0] OPC_PAUSE   = 16'h0001;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [IN_B*8-1:0] data;
    logic [IEW-1:0]    empty;
    logic              valid;
    logic              payload;
    logic              sop;
    logic              eop;
    logic              crc_bad;
  } rxf_in_t;
  typedef struct packed {
    logic [OUT_B*8-1:0] data;
    logic [EW-1:0]      empty;
    logic               valid;
    logic               sop;
    logic               eop;
    logic [1:0]         error;
    logic               fcs_valid;
    logic               fcs_error;
  } rxf_out_t;
  typedef struct packed {
    logic        valid;
    logic [15:0] quanta;
  } rxf_pause_t;
endpackage : rxf_pkg
`default_nettype wire

// >>> test/rxf_sink.sv
// Client-side stream sink model that collects received packets
`timescale 1ns/100ps
`default_nettype none
module rxf_sink (
  input wire logic              aclk,    // Receive MAC clock
  input wire logic              aresetn, // Sync reset, active low
  input wire rxf_pkg::rxf_out_t st_i     // Widened stream from the MAC
);
  import rxf_pkg::*;
  logic [7:0] got_q[$];
  int         frames;
  int         bad_cnt;
  logic       in_pkt;
  logic [1:0] err_l;
  logic       fe_l;
  // ----------------------------------------
  // Sink: no ready, so every word is taken the cycle it shows
  // ----------------------------------------
  // Samples before the edge's own updates land, like a real flop
  always @(posedge aclk) begin
    if (!aresetn) begin
      in_pkt = 1'b0;
      frames = 0;
      bad_cnt = 0;
    end else if (st_i.valid) begin
      if (st_i.sop)
        got_q.delete();
      if (!st_i.sop && !in_pkt)
        bad_cnt++;
      if (!st_i.eop && (st_i.empty != '0 || st_i.fcs_valid))
        bad_cnt++;
      if (st_i.eop && !st_i.fcs_valid)
        bad_cnt++;
      // Bytes go MSB first; empty trims low lanes on the last word
      for (int k = 0; k < OUT_B - (st_i.eop ? int'(st_i.empty) : 0); k++)
        got_q.push_back(st_i.data[OUT_B*8-1-8*k -: 8]);
      in_pkt = !st_i.eop;
      if (st_i.eop) begin
        err_l = st_i.error;
        fe_l = st_i.fcs_error;
        frames++;
      end
    end else if (st_i.sop || st_i.eop || st_i.fcs_valid) begin
      bad_cnt++;
    end
  end
endmodule : rxf_sink
`default_nettype wire

// >>> test/rxf_mac_tb_top.sv
// Self-checking bench for the receive filter and client port
`timescale 1ns/100ps
`default_nettype none
module rxf_mac_tb_top;
  import rxf_pkg::*;
  logic        aclk;
  logic        aresetn;
  rxf_in_t     rx_i;
  rxf_out_t    st_o;
  rxf_pause_t  pause_o;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, strb_v;
  logic [1:0]  bresp, rresp;
  logic [7:0]  exp_q[$];
  int          fail_count, checks_done, pause_cnt;
  logic [15:0] pause_q;
  localparam logic [47:0] DA_U = 48'h0211_2233_4455;
  localparam logic [47:0] DA_X = 48'h0A11_2233_4466;
  localparam logic [47:0] DA_M = 48'h0111_2233_4455;
  localparam logic [47:0] DA_B = 48'hFFFF_FFFF_FFFF;

  rxf_mac dut_u (.aclk(aclk), .aresetn(aresetn), .rx_i(rx_i), .st_o(st_o), .pause_o(pause_o),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp));
  rxf_sink sink_u (.aclk(aclk), .aresetn(aresetn), .st_i(st_o));

  // Clock at 25 MHz
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Counts pause requests handed to the transmit side
  always @(posedge aclk) begin
    if (aresetn && pause_o.valid) begin
      pause_cnt++;
      pause_q = pause_o.quanta;
    end
  end
  // ----------------------------------------
  // Reporting
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // ----------------------------------------
  // Register bus master
  // ----------------------------------------
  // Ready is combinational, so it is judged at the falling edge where it is settled
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= strb_v;
    bready <= 1'b1;
    do @(negedge aclk); while (!(awready && wready));
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge aclk); while (!bvalid);
    check({30'b0, bresp}, {30'b0, er});
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    check(rdata, d);
    check({30'b0, rresp}, {30'b0, er});
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd
  // ----------------------------------------
  // Frame driver and comparison
  // ----------------------------------------
  // Sends one frame in 40-byte beats, then a gap beat full of junk bytes
  task automatic send(input logic [47:0] da, input int len, input logic [15:0] et, input logic bad);
    rxf_in_t t;
    int      n;
    exp_q.delete();
    for (int i = 0; i < len; i++)
      exp_q.push_back(i < 6 ? da[47-8*i -: 8] : i == 12 ? et[15:8] : i == 13 ? et[7:0] :
        i == 15 ? 8'h01 : i == 14 ? 8'h00 : i == 16 ? 8'h12 : i == 17 ? 8'h34 : 8'(i ^ 8'h5A));
    for (int s = 0; s < len; s += IN_B) begin
      n = (len - s < IN_B) ? len - s : IN_B;
      t = '0;
      t.valid = 1'b1;
      t.payload = 1'b1;
      t.sop = (s == 0);
      t.eop = (s + IN_B >= len);
      t.empty = IEW'(IN_B - n);
      t.crc_bad = bad & t.eop;
      for (int k = 0; k < n; k++)
        t.data[IN_B*8-1-8*k -: 8] = exp_q[s+k];
      @(posedge aclk);
      rx_i <= t;
    end
    t = '0;
    t.valid = 1'b1;
    t.data = {IN_B{8'hA5}};
    @(posedge aclk);
    rx_i <= t;
    @(posedge aclk);
    rx_i <= '0;
  endtask : send
  // Output follows input end within three cycles, so twelve covers it
  task automatic run(input logic [47:0] da, input int len, input logic [15:0] et, input logic bad,
                     input logic keep, input logic [1:0] err, input logic fe);
    int n0;
    n0 = sink_u.frames;
    send(da, len, et, bad);
    repeat (12) @(posedge aclk);
    @(negedge aclk);
    check(32'(sink_u.frames - n0), {31'b0, keep});
    if (keep) begin
      check(32'(sink_u.got_q.size()), 32'(len));
      foreach (exp_q[i])
        check({24'b0, sink_u.got_q[i]}, {24'b0, exp_q[i]});
      check({29'b0, sink_u.err_l, sink_u.fe_l}, {29'b0, err, fe});
    end
  endtask : run
  task automatic pz(input logic [47:0] da, input logic hit);
    int n0;
    n0 = pause_cnt;
    run(da, 64, 16'h8808, 1'b0, 1'b1, 2'b00, 1'b0);
    check(32'(pause_cnt - n0), {31'b0, hit});
    if (hit)
      check({16'b0, pause_q}, 32'h0000_1234);
  endtask : pz
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    rx_i = '0;
    fail_count = 0;
    checks_done = 0;
    pause_cnt = 0;
    strb_v = 4'hF;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(16'h040C, FILT_RST, RESP_OK);
    rd(16'h0500, MADDR_RST, RESP_OK);
    rd(16'h050C, PAUSE_RST, RESP_OK);
    rd(16'h07FC, 32'h0000_0000, RESP_ERR);
    wr(16'h07FC, 32'h1234_5678, RESP_ERR);
    // Partial strobes touch only their own byte lanes
    strb_v = 4'h2;
    wr(16'h0504, 32'hAABB_CCDD, RESP_OK);
    strb_v = 4'hF;
    rd(16'h0504, 32'h0000_CC00, RESP_OK);
    run(DA_U, 100, 16'h0800, 1'b0, 1'b1, 2'b00, 1'b0);
    rd(16'h0510, 32'h0000_0001, RESP_OK);
    run(DA_M, 80, 16'h0800, 1'b0, 1'b1, 2'b00, 1'b0);
    rd(16'h0510, 32'h0000_0002, RESP_OK);
    run(DA_B, 64, 16'h0800, 1'b0, 1'b1, 2'b00, 1'b0);
    rd(16'h0510, 32'h0000_0006, RESP_OK);
    wr(16'h0510, 32'hFFFF_FFFF, RESP_OK);
    rd(16'h0510, 32'h0000_0006, RESP_OK);
    wr(16'h0504, DA_U[31:0], RESP_OK);
    wr(16'h0508, {16'b0, DA_U[47:32]}, RESP_OK);
    wr(16'h0500, 32'h4000_0001, RESP_OK);
    rd(16'h0500, 32'h4000_0001, RESP_OK);
    run(DA_U, 100, 16'h0800, 1'b0, 1'b1, 2'b00, 1'b0);
    run(DA_X, 100, 16'h0800, 1'b0, 1'b0, 2'b00, 1'b0);
    rd(16'h0510, 32'h0000_0009, RESP_OK);
    wr(16'h0500, 32'h4000_0000, RESP_OK);
    run(DA_U, 100, 16'h0800, 1'b0, 1'b0, 2'b00, 1'b0);
    wr(16'h040C, 32'h0000_0001, RESP_OK);
    run(DA_X, 100, 16'h0800, 1'b0, 1'b1, 2'b00, 1'b0);
    wr(16'h040C, 32'h0000_0000, RESP_OK);
    wr(16'h0500, 32'h0000_0000, RESP_OK);
    run(DA_U, 100, 16'h0800, 1'b1, 1'b1, 2'b10, 1'b1);
    run(DA_U, 63, 16'h0800, 1'b0, 1'b1, 2'b01, 1'b1);
    run(DA_U, 64, 16'h0800, 1'b0, 1'b1, 2'b00, 1'b0);
    run(DA_U, 9, 16'h0800, 1'b0, 1'b1, 2'b01, 1'b1);
    run(DA_U, 8, 16'h0800, 1'b0, 1'b1, 2'b01, 1'b0);
    pz(DA_U, 1'b0);
    pz(DA_M, 1'b0);
    wr(16'h050C, 32'h0000_0002, RESP_OK);
    pz(DA_U, 1'b0);
    pz(DA_M, 1'b1);
    wr(16'h050C, 32'h0000_0001, RESP_OK);
    pz(DA_U, 1'b1);
    pz(DA_M, 1'b0);
    check(32'(sink_u.bad_cnt), 32'h0000_0000);
    close_out();
  end
  // Watchdog: the sequence needs about four hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    close_out();
  end
endmodule : rxf_mac_tb_top
`default_nettype wire
